// ==== cpa_pkg.sv ====
package cpa_pkg;
  // Notes on behaviour
  // - I/O bit set, clear and skip work only on I/O addresses 0x00 to 0x1F.
  // - I/O bit set or clear writes only the addressed bit, others untouched.
  // - Port ops reach I/O 0x00-0x3F; data space sees them at plus 0x20.
  // - Extended I/O 0x60-0xFF is reached only by data-space load and store.
  // - Register add, with or without carry, writes sum, sets Z C N V H, one cycle.
  // - Word add immediate adds constant to pair, sets Z C N V S, two cycles.
  // - Word subtract immediate subtracts from pair, sets Z C N V S, two cycles.
  // - Register subtract, with or without borrow, sets Z C N V H, one cycle.
  // - Immediate subtract, with or without borrow, sets Z C N V H, one cycle.
  // - AND, OR, XOR on registers or constant set only Z N V S, one cycle.
  // - Set bits ORs mask in; clear bits ANDs with 0xFF minus mask; Z N V.
  // - Increment, decrement, test and clear take one cycle, set only Z N V S.
  // - Indirect jump loads PC from Z pair, keeps flags, takes two cycles.

  // ==========================================================
  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // ==========================================================
  // I/O address map
  localparam logic [7:0] BIT_IO_MAX = 8'h1f;
  localparam logic [7:0] PORT_IO_MAX = 8'h3f;
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] EXT_IO_FIRST = 8'h60;
  localparam logic [7:0] FULL_MASK = 8'hff;

  // ==========================================================
  // Software registers and error bits
  localparam logic [3:0] REG_FLAGS = 4'h0;
  localparam logic [3:0] REG_RESULT = 4'h1;
  localparam logic [3:0] REG_PC_LO = 4'h2;
  localparam logic [3:0] REG_PC_HI = 4'h3;
  localparam logic [3:0] REG_ERROR = 4'h4;
  localparam int ERR_BIT = 0;
  localparam int ERR_PORT = 1;
  localparam int ERR_MEM = 2;

  // ==========================================================
  // Operations and state
  typedef enum logic [4:0] {
    CPA_NOP, CPA_ADD, CPA_ADD_CARRY, CPA_SUB,
    CPA_SUBTRACT_REGISTERS_WITH_BORROW, CPA_SUBTRACT_IMMEDIATE,
    CPA_SUBTRACT_IMMEDIATE_WITH_BORROW, CPA_AND, CPA_BITWISE_AND_IMMEDIATE,
    CPA_OR, CPA_BITWISE_OR_IMMEDIATE, CPA_BITWISE_XOR_REGISTERS,
    CPA_SET_BITS_IN_REGISTER, CPA_CLEAR_BITS_IN_REGISTER, CPA_INCREMENT,
    CPA_DECREMENT_REGISTER, CPA_TEST_ZERO_OR_MINUS, CPA_CLEAR_REGISTER_OP,
    CPA_WORD_ADD_IMMEDIATE, CPA_WORD_SUBTRACT_IMMEDIATE, CPA_INDIRECT_JUMP,
    CPA_PORT_READ, CPA_PORT_WRITE, CPA_DATA_SPACE_LOAD, CPA_DATA_SPACE_STORE,
    CPA_IO_BIT_SET, CPA_IO_BIT_CLEAR, CPA_IO_BIT_SKIP_IF_ONE,
    CPA_IO_BIT_SKIP_IF_ZERO
  } cpa_op_e;

  typedef enum logic [2:0] {
    CPA_IDLE, CPA_WORD, CPA_JUMP, CPA_IORD, CPA_BIT
  } cpa_fsm_e;

  typedef struct packed {
    cpa_fsm_e fsm;
    logic [7:0] result;
    logic rd_we;
    logic [15:0] word;
    logic word_we;
    logic [15:0] pc;
    logic pc_load;
    logic skip;
    logic [7:0] flags;
    logic [7:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_mask;
    logic io_we;
    logic io_re;
    logic rd_load;
    logic skip_val;
    logic [2:0] bit_sel;
    logic [2:0] err;
    logic [7:0] rdata;
  } cpa_state_s;

  localparam cpa_state_s STATE_RESET = '0;
endpackage : cpa_pkg

// ==== cpa_addsub.sv ====
`timescale 1ns/100ps
module cpa_addsub
  import cpa_pkg::*;
#(
  parameter int W = 8
) (
  // Operands
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic cin_i,
  input wire logic sub_i,
  // Result and raw flags
  output logic [W-1:0] sum_o,
  output logic carry_o,
  output logic half_o,
  output logic ovf_o
);
  logic [W:0] full;
  logic [4:0] low;

  assign full = sub_i ?
    {1'b0, a_i} - {1'b0, b_i} - {{W{1'b0}}, cin_i} :
    {1'b0, a_i} + {1'b0, b_i} + {{W{1'b0}}, cin_i};
  assign low = sub_i ?
    {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i} :
    {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
  assign sum_o = full[W-1:0];
  assign carry_o = full[W];
  assign half_o = low[4];
  // Signed overflow: operand signs agree (add) or differ (sub), result flips
  assign ovf_o = (sub_i ? (a_i[W-1] != b_i[W-1]) : (a_i[W-1] == b_i[W-1]))
    && (sum_o[W-1] != a_i[W-1]);
endmodule : cpa_addsub

// ==== cpa_io_map.sv ====
`timescale 1ns/100ps
module cpa_io_map
  import cpa_pkg::*;
(
  // Access kind and address
  input wire logic [7:0] addr_i,
  input wire logic is_bit_i,
  input wire logic is_port_i,
  input wire logic is_mem_i,
  // Decode
  output logic legal_o,
  output logic [7:0] daddr_o
);
  always_comb begin
    legal_o = 1'b0;
    daddr_o = addr_i;
    if (is_bit_i) begin
      legal_o = addr_i <= BIT_IO_MAX;
      daddr_o = addr_i + IO_DATA_OFFSET;
    end else if (is_port_i) begin
      // Extended area lies beyond the port range, so it is refused here
      legal_o = addr_i <= PORT_IO_MAX;
      daddr_o = addr_i + IO_DATA_OFFSET;
    end else if (is_mem_i) begin
      // Below the I/O window lie the working registers
      legal_o = addr_i >= IO_DATA_OFFSET;
    end
  end
endmodule : cpa_io_map

// ==== cpa_alu.sv ====
`timescale 1ns/100ps
module cpa_alu
  import cpa_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Decoder request
  input wire logic op_valid_i,
  input wire cpa_op_e op_i,
  input wire logic [7:0] rd_data_i,
  input wire logic [7:0] rr_data_i,
  input wire logic [7:0] imm_i,
  input wire logic [15:0] pair_i,
  input wire logic [15:0] z_ptr_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [2:0] bit_i,
  output logic ready_o,
  // Register file write-back
  output logic [7:0] result_o,
  output logic rd_we_o,
  output logic [15:0] word_o,
  output logic word_we_o,
  // Program flow and status
  output logic [15:0] pc_o,
  output logic pc_load_o,
  output logic skip_o,
  output logic [7:0] flags_o,
  // I/O and data space
  output logic [7:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic [7:0] io_mask_o,
  output logic io_we_o,
  output logic io_re_o,
  input wire logic [7:0] io_rdata_i,
  // Software register port
  input wire logic [3:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_we_i,
  input wire logic bus_re_i,
  output logic [7:0] bus_rdata_o
);
  // ==========================================================
  // State and operand paths
  cpa_state_s cur;
  cpa_state_s nx;
  logic take;
  logic sub8;
  logic cin8;
  logic [7:0] b8;
  logic [7:0] s8;
  logic c8;
  logic h8;
  logic v8;
  logic [15:0] s16;
  logic c16;
  logic v16;
  logic is_bit;
  logic is_port;
  logic is_mem;
  logic map_ok;
  logic [7:0] map_addr;

  assign ready_o = cur.fsm == CPA_IDLE;
  assign take = op_valid_i && ready_o;

  assign sub8 = op_i inside {CPA_SUB, CPA_SUBTRACT_REGISTERS_WITH_BORROW,
    CPA_SUBTRACT_IMMEDIATE, CPA_SUBTRACT_IMMEDIATE_WITH_BORROW,
    CPA_DECREMENT_REGISTER};
  assign cin8 = (op_i inside {CPA_ADD_CARRY,
    CPA_SUBTRACT_REGISTERS_WITH_BORROW,
    CPA_SUBTRACT_IMMEDIATE_WITH_BORROW}) && cur.flags[FLAG_C];
  assign b8 = (op_i inside {CPA_SUBTRACT_IMMEDIATE,
    CPA_SUBTRACT_IMMEDIATE_WITH_BORROW}) ? imm_i :
    (op_i inside {CPA_INCREMENT, CPA_DECREMENT_REGISTER}) ? 8'h01 :
    rr_data_i;

  assign is_bit = op_i inside {CPA_IO_BIT_SET, CPA_IO_BIT_CLEAR,
    CPA_IO_BIT_SKIP_IF_ONE, CPA_IO_BIT_SKIP_IF_ZERO};
  assign is_port = op_i inside {CPA_PORT_READ, CPA_PORT_WRITE};
  assign is_mem = op_i inside {CPA_DATA_SPACE_LOAD, CPA_DATA_SPACE_STORE};

  cpa_addsub #(.W(8)) u_add8 (
    .a_i(rd_data_i),
    .b_i(b8),
    .cin_i(cin8),
    .sub_i(sub8),
    .sum_o(s8),
    .carry_o(c8),
    .half_o(h8),
    .ovf_o(v8)
  );

  cpa_addsub #(.W(16)) u_add16 (
    .a_i(pair_i),
    .b_i({8'h00, imm_i}),
    .cin_i(1'b0),
    .sub_i(op_i == CPA_WORD_SUBTRACT_IMMEDIATE),
    .sum_o(s16),
    .carry_o(c16),
    .half_o(),
    .ovf_o(v16)
  );

  cpa_io_map u_map (
    .addr_i(io_addr_i),
    .is_bit_i(is_bit),
    .is_port_i(is_port),
    .is_mem_i(is_mem),
    .legal_o(map_ok),
    .daddr_o(map_addr)
  );

  // ==========================================================
  // Logic unit and its flag update
  function automatic logic [7:0] logic_res(input cpa_op_e op,
      input logic [7:0] a, input logic [7:0] r, input logic [7:0] k);
    case (op)
      CPA_AND: logic_res = a & r;
      CPA_BITWISE_AND_IMMEDIATE: logic_res = a & k;
      CPA_OR: logic_res = a | r;
      CPA_BITWISE_OR_IMMEDIATE: logic_res = a | k;
      CPA_SET_BITS_IN_REGISTER: logic_res = a | k;
      CPA_CLEAR_BITS_IN_REGISTER: logic_res = a & (FULL_MASK - k);
      CPA_BITWISE_XOR_REGISTERS: logic_res = a ^ r;
      CPA_TEST_ZERO_OR_MINUS: logic_res = a & a;
      CPA_CLEAR_REGISTER_OP: logic_res = a ^ a;
      default: logic_res = a;
    endcase
  endfunction : logic_res

  // Z, N and S from the result, V as given; C and H kept
  function automatic logic [7:0] znv(input logic [7:0] f,
      input logic [7:0] r, input logic v);
    znv = f;
    znv[FLAG_Z] = r == 8'h00;
    znv[FLAG_N] = r[7];
    znv[FLAG_V] = v;
    znv[FLAG_S] = r[7] ^ v;
  endfunction : znv

  // ==========================================================
  // Next state
  always_comb begin
    nx = cur;
    nx.rd_we = 1'b0;
    nx.word_we = 1'b0;
    nx.pc_load = 1'b0;
    nx.skip = 1'b0;
    nx.io_we = 1'b0;
    nx.io_re = 1'b0;
    nx.rdata = 8'h00;
    if (bus_re_i) begin
      case (bus_addr_i)
        REG_FLAGS: nx.rdata = cur.flags;
        REG_RESULT: nx.rdata = cur.result;
        REG_PC_LO: nx.rdata = cur.pc[7:0];
        REG_PC_HI: nx.rdata = cur.pc[15:8];
        REG_ERROR: nx.rdata = {5'h00, cur.err};
        default: nx.rdata = 8'h00;
      endcase
    end
    // Software writes first, so a hardware update in the same cycle wins
    if (bus_we_i && bus_addr_i == REG_FLAGS) begin
      nx.flags = bus_wdata_i;
    end
    if (bus_we_i && bus_addr_i == REG_ERROR) begin
      nx.err = cur.err & ~bus_wdata_i[2:0];
    end
    case (cur.fsm)
      CPA_IDLE: begin
        if (op_valid_i) begin
          case (op_i)
            CPA_ADD, CPA_ADD_CARRY, CPA_SUB,
            CPA_SUBTRACT_REGISTERS_WITH_BORROW, CPA_SUBTRACT_IMMEDIATE,
            CPA_SUBTRACT_IMMEDIATE_WITH_BORROW: begin
              nx.result = s8;
              nx.rd_we = 1'b1;
              nx.flags = znv(cur.flags, s8, v8);
              nx.flags[FLAG_C] = c8;
              nx.flags[FLAG_H] = h8;
              // Borrow chains, and add with carry when C is set, keep Z only while every byte was zero
              if (cin8 || op_i == CPA_SUBTRACT_REGISTERS_WITH_BORROW ||
                  op_i == CPA_SUBTRACT_IMMEDIATE_WITH_BORROW) begin
                nx.flags[FLAG_Z] = (s8 == 8'h00) && cur.flags[FLAG_Z];
              end
            end
            CPA_AND, CPA_BITWISE_AND_IMMEDIATE, CPA_OR,
            CPA_BITWISE_OR_IMMEDIATE, CPA_BITWISE_XOR_REGISTERS,
            CPA_SET_BITS_IN_REGISTER, CPA_CLEAR_BITS_IN_REGISTER,
            CPA_TEST_ZERO_OR_MINUS, CPA_CLEAR_REGISTER_OP: begin
              nx.result = logic_res(op_i, rd_data_i, rr_data_i, imm_i);
              nx.rd_we = 1'b1;
              nx.flags = znv(cur.flags, nx.result, 1'b0);
            end
            CPA_INCREMENT, CPA_DECREMENT_REGISTER: begin
              nx.result = s8;
              nx.rd_we = 1'b1;
              nx.flags = znv(cur.flags, s8, v8);
            end
            CPA_WORD_ADD_IMMEDIATE, CPA_WORD_SUBTRACT_IMMEDIATE: begin
              nx.word = s16;
              nx.flags[FLAG_C] = c16;
              nx.flags[FLAG_Z] = s16 == 16'h0000;
              nx.flags[FLAG_N] = s16[15];
              nx.flags[FLAG_V] = v16;
              nx.flags[FLAG_S] = s16[15] ^ v16;
              nx.fsm = CPA_WORD;
            end
            CPA_INDIRECT_JUMP: begin
              nx.pc = z_ptr_i;
              nx.fsm = CPA_JUMP;
            end
            CPA_PORT_READ, CPA_DATA_SPACE_LOAD: begin
              if (map_ok) begin
                nx.io_addr = map_addr;
                nx.io_re = 1'b1;
                nx.rd_load = 1'b1;
                nx.fsm = CPA_IORD;
              end
            end
            CPA_PORT_WRITE, CPA_DATA_SPACE_STORE: begin
              if (map_ok) begin
                nx.io_addr = map_addr;
                nx.io_wdata = rd_data_i;
                nx.io_mask = FULL_MASK;
                nx.io_we = 1'b1;
              end
            end
            CPA_IO_BIT_SET, CPA_IO_BIT_CLEAR: begin
              if (map_ok) begin
                nx.io_addr = map_addr;
                nx.io_mask = 8'h01 << bit_i;
                nx.io_wdata = op_i == CPA_IO_BIT_SET ? FULL_MASK : 8'h00;
                nx.io_we = 1'b1;
                nx.fsm = CPA_BIT;
              end
            end
            CPA_IO_BIT_SKIP_IF_ONE, CPA_IO_BIT_SKIP_IF_ZERO: begin
              if (map_ok) begin
                nx.io_addr = map_addr;
                nx.io_re = 1'b1;
                nx.rd_load = 1'b0;
                nx.bit_sel = bit_i;
                nx.skip_val = op_i == CPA_IO_BIT_SKIP_IF_ONE;
                nx.fsm = CPA_IORD;
              end
            end
            default: begin
            end
          endcase
          // Refused accesses are recorded; the set wins over a clear
          if (!map_ok && is_bit) nx.err[ERR_BIT] = 1'b1;
          if (!map_ok && is_port) nx.err[ERR_PORT] = 1'b1;
          if (!map_ok && is_mem) nx.err[ERR_MEM] = 1'b1;
        end
      end
      CPA_WORD: begin
        nx.word_we = 1'b1;
        nx.fsm = CPA_IDLE;
      end
      CPA_JUMP: begin
        nx.pc_load = 1'b1;
        nx.fsm = CPA_IDLE;
      end
      CPA_IORD: begin
        if (cur.rd_load) begin
          nx.result = io_rdata_i;
          nx.rd_we = 1'b1;
        end else begin
          nx.skip = io_rdata_i[cur.bit_sel] == cur.skip_val;
        end
        nx.fsm = CPA_IDLE;
      end
      CPA_BIT: nx.fsm = CPA_IDLE;
      default: nx.fsm = CPA_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur <= STATE_RESET;
    end else begin
      cur <= nx;
    end
  end

  assign result_o = cur.result;
  assign rd_we_o = cur.rd_we;
  assign word_o = cur.word;
  assign word_we_o = cur.word_we;
  assign pc_o = cur.pc;
  assign pc_load_o = cur.pc_load;
  assign skip_o = cur.skip;
  assign flags_o = cur.flags;
  assign io_addr_o = cur.io_addr;
  assign io_wdata_o = cur.io_wdata;
  assign io_mask_o = cur.io_mask;
  assign io_we_o = cur.io_we;
  assign io_re_o = cur.io_re;
  assign bus_rdata_o = cur.rdata;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  bit_range_a: assert property (
    take && op_i == CPA_IO_BIT_SET && io_addr_i > BIT_IO_MAX
    |=> !io_we_o && cur.err[ERR_BIT])
    else $error("bit op beyond 0x1f was not refused");
  bit_mask_a: assert property (
    take && op_i == CPA_IO_BIT_CLEAR && io_addr_i <= BIT_IO_MAX
    |=> io_we_o && $onehot(io_mask_o) && io_wdata_o == 8'h00
      && io_mask_o == (8'h01 << $past(bit_i)))
    else $error("bit clear touches more than one bit");
  io_offset_a: assert property (
    take && op_i == CPA_PORT_READ && io_addr_i <= PORT_IO_MAX
    |=> io_re_o && io_addr_o == $past(io_addr_i) + IO_DATA_OFFSET
      ##1 rd_we_o)
    else $error("port read address or write-back wrong");
  ext_port_a: assert property (
    take && op_i == CPA_PORT_WRITE && io_addr_i > PORT_IO_MAX
    |=> !io_we_o && cur.err[ERR_PORT])
    else $error("port write reached extended area");
  ext_store_a: assert property (
    take && op_i == CPA_DATA_SPACE_STORE && io_addr_i >= EXT_IO_FIRST
    |=> io_we_o && io_addr_o == $past(io_addr_i))
    else $error("store to extended area lost");
  add_flags_a: assert property (
    take && op_i == CPA_ADD
    |=> rd_we_o && result_o == $past(rd_data_i + rr_data_i)
      && flags_o[FLAG_H] == ($past(rd_data_i[3:0]) + $past(rr_data_i[3:0])
      > 15) && ready_o)
    else $error("add result or half carry wrong");
  word_add_a: assert property (
    take && op_i == CPA_WORD_ADD_IMMEDIATE
    |=> !ready_o && !word_we_o ##1 word_we_o
      && word_o == $past(pair_i, 2) + $past(imm_i, 2))
    else $error("word add timing or sum wrong");
  word_sub_a: assert property (
    take && op_i == CPA_WORD_SUBTRACT_IMMEDIATE
    |=> flags_o[FLAG_C] == ($past(imm_i) > $past(pair_i))
      ##1 word_we_o && word_o == $past(pair_i, 2) - $past(imm_i, 2))
    else $error("word subtract borrow or timing wrong");
  sub_carry_a: assert property (
    take && op_i == CPA_SUB
    |=> flags_o[FLAG_C] == ($past(rr_data_i) > $past(rd_data_i))
      && flags_o[FLAG_Z] == ($past(rd_data_i) == $past(rr_data_i)))
    else $error("subtract borrow or zero wrong");
  subtract_immediate_result_a: assert property (
    take && op_i == CPA_SUBTRACT_IMMEDIATE
    |=> rd_we_o && result_o == $past(rd_data_i - imm_i))
    else $error("immediate subtract result wrong");
  xor_flags_a: assert property (
    take && op_i == CPA_BITWISE_XOR_REGISTERS
    |=> !flags_o[FLAG_V] && flags_o[FLAG_C] == $past(flags_o[FLAG_C])
      && result_o == $past(rd_data_i ^ rr_data_i))
    else $error("xor changed carry or result wrong");
  clear_bits_a: assert property (
    take && op_i == CPA_CLEAR_BITS_IN_REGISTER
    |=> result_o == $past(rd_data_i & ~imm_i))
    else $error("clear bits result wrong");
  dec_flags_a: assert property (
    take && op_i == CPA_DECREMENT_REGISTER
    |=> result_o == $past(rd_data_i) - 8'h01
      && flags_o[FLAG_H] == $past(flags_o[FLAG_H])
      && flags_o[FLAG_V] == ($past(rd_data_i) == 8'h80))
    else $error("decrement result or flags wrong");
  clear_reg_a: assert property (
    take && op_i == CPA_CLEAR_REGISTER_OP
    |=> result_o == 8'h00 && flags_o[FLAG_Z] && !flags_o[FLAG_N])
    else $error("clear register wrong");
  jump_pc_a: assert property (
    take && op_i == CPA_INDIRECT_JUMP && !bus_we_i
    |=> !ready_o && flags_o == $past(flags_o)
      ##1 pc_load_o && pc_o == $past(z_ptr_i, 2))
    else $error("indirect jump wrong");
  sign_flag_a: assert property (
    take && op_i == CPA_ADD_CARRY
    |=> flags_o[FLAG_S] == (flags_o[FLAG_N] ^ flags_o[FLAG_V]))
    else $error("sign flag not n xor v");
endmodule : cpa_alu

// ==== cpa_io_model.sv ====
`timescale 1ns/100ps
module cpa_io_model (
  // Core side of the data space
  input wire logic clk_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_mask_i,
  input wire logic io_we_i,
  input wire logic io_re_i,
  output logic [7:0] io_rdata_o
);
  // ==========================================================
  // Register space with a known preset
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  // Masked write keeps write-one-to-clear neighbours intact
  always @(posedge clk_i) begin
    if (io_we_i) begin
      mem[io_addr_i] <= (mem[io_addr_i] & ~io_mask_i)
        | (io_wdata_i & io_mask_i);
    end
    if (io_re_i) begin
      last <= mem[io_addr_i];
    end
  end
  // Outside a read the lines show no stale value
  assign io_rdata_o = io_re_i ? mem[io_addr_i] : ~last;
endmodule : cpa_io_model

// ==== cpu_alu_and_io_access_tb.sv ====
`timescale 1ns/100ps
module cpu_alu_and_io_access_tb
  import cpa_pkg::*;
;
  // ==========================================================
  // Design ports and bench state
  logic clk_i = 1'b0, reset_i = 1'b1, op_valid_i = 1'b0;
  logic bus_we_i = 1'b0, bus_re_i = 1'b0;
  cpa_op_e op_i = CPA_NOP, o = CPA_NOP;
  logic [7:0] rd_data_i = 8'h00, rr_data_i = 8'h00, imm_i = 8'h00;
  logic [7:0] io_addr_i = 8'h00, bus_wdata_i = 8'h00, io_rdata_i;
  logic [15:0] pair_i = 16'h0000, z_ptr_i = 16'h0000, word_o, pc_o;
  logic [2:0] bit_i = 3'h0;
  logic [3:0] bus_addr_i = 4'h0;
  logic ready_o, rd_we_o, word_we_o, pc_load_o, skip_o, io_we_o, io_re_o;
  logic [7:0] result_o, flags_o, io_addr_o, io_wdata_o, io_mask_o;
  logic [7:0] bus_rdata_o, ef = 8'h00, a, r, k;
  logic [15:0] ex, px;
  logic [23:0] wx;
  int fails = 0, n_tests = 0, seed = 32'h4ee7a0eb;
  cpa_op_e ops [17] = '{CPA_ADD, CPA_ADD_CARRY, CPA_SUB,
    CPA_SUBTRACT_REGISTERS_WITH_BORROW, CPA_SUBTRACT_IMMEDIATE,
    CPA_SUBTRACT_IMMEDIATE_WITH_BORROW, CPA_AND, CPA_BITWISE_AND_IMMEDIATE,
    CPA_OR, CPA_BITWISE_OR_IMMEDIATE, CPA_BITWISE_XOR_REGISTERS,
    CPA_SET_BITS_IN_REGISTER, CPA_CLEAR_BITS_IN_REGISTER, CPA_INCREMENT,
    CPA_DECREMENT_REGISTER, CPA_TEST_ZERO_OR_MINUS, CPA_CLEAR_REGISTER_OP};
  logic [7:0] cor [4] = '{8'h7f, 8'h80, 8'hff, 8'h0f};
  logic [7:0] wh [4] = '{8'hff, 8'h00, 8'h7f, 8'h80};
  logic [7:0] ra [6] = '{8'h05, 8'h1f, 8'h3f, 8'h60, 8'hff, 8'h25};
  logic [7:0] ea [6] = '{8'h25, 8'h3f, 8'h5f, 8'h60, 8'hff, 8'h25};
  logic [7:0] rv [6] = '{8'hff, 8'h64, 8'h05, 8'h3a, 8'ha5, 8'hff};

  cpa_alu cpa_alu_inst (.clk_i(clk_i), .reset_i(reset_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .rd_data_i(rd_data_i),
    .rr_data_i(rr_data_i), .imm_i(imm_i), .pair_i(pair_i),
    .z_ptr_i(z_ptr_i), .io_addr_i(io_addr_i), .bit_i(bit_i),
    .ready_o(ready_o), .result_o(result_o), .rd_we_o(rd_we_o),
    .word_o(word_o), .word_we_o(word_we_o), .pc_o(pc_o),
    .pc_load_o(pc_load_o), .skip_o(skip_o), .flags_o(flags_o),
    .io_addr_o(io_addr_o), .io_wdata_o(io_wdata_o), .io_mask_o(io_mask_o),
    .io_we_o(io_we_o), .io_re_o(io_re_o), .io_rdata_i(io_rdata_i),
    .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_we_i(bus_we_i), .bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o));
  cpa_io_model cpa_io_model_inst (.clk_i(clk_i), .io_addr_i(io_addr_o),
    .io_wdata_i(io_wdata_o), .io_mask_i(io_mask_o), .io_we_i(io_we_o),
    .io_re_i(io_re_o), .io_rdata_o(io_rdata_i));

  initial forever #12.5 clk_i = ~clk_i;
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    test_done();
  end

  // ==========================================================
  // Expected results
  function automatic logic [15:0] alu(input cpa_op_e o,
    input logic [7:0] a, r, k, f);
    logic [8:0] t;
    logic [7:0] b;
    logic c, h, v, cc, ar;
    cc = o inside {CPA_SUBTRACT_REGISTERS_WITH_BORROW,
      CPA_SUBTRACT_IMMEDIATE_WITH_BORROW};
    c = (cc || o == CPA_ADD_CARRY) & f[FLAG_C];
    b = o inside {CPA_ADD, CPA_ADD_CARRY, CPA_SUB, CPA_AND, CPA_OR,
      CPA_SUBTRACT_REGISTERS_WITH_BORROW, CPA_BITWISE_XOR_REGISTERS} ? r : k;
    h = 1'b0;
    v = 1'b0;
    ar = 1'b0;
    case (o)
      CPA_ADD, CPA_ADD_CARRY: begin
        t = a + b + c;
        h = a[3:0] + b[3:0] + c > 5'h0f;
        v = a[7] == b[7] && t[7] != a[7];
        ar = 1'b1;
      end
      CPA_AND, CPA_BITWISE_AND_IMMEDIATE: t = a & b;
      CPA_OR, CPA_BITWISE_OR_IMMEDIATE, CPA_SET_BITS_IN_REGISTER: t = a | b;
      CPA_BITWISE_XOR_REGISTERS: t = a ^ b;
      CPA_CLEAR_BITS_IN_REGISTER: t = a & (8'hff - k);
      CPA_INCREMENT: begin
        t = a + 8'h01;
        v = a == 8'h7f;
      end
      CPA_DECREMENT_REGISTER: begin
        t = a - 8'h01;
        v = a == 8'h80;
      end
      CPA_TEST_ZERO_OR_MINUS: t = a & a;
      CPA_CLEAR_REGISTER_OP: t = a ^ a;
      default: begin
        t = a - b - c;
        h = {1'b0, a[3:0]} < b[3:0] + c;
        v = a[7] != b[7] && t[7] != a[7];
        ar = 1'b1;
      end
    endcase
    f[FLAG_Z] = t[7:0] == 8'h00 && (!(cc || c) || f[FLAG_Z]);
    f[FLAG_N] = t[7];
    f[FLAG_V] = v;
    f[FLAG_S] = t[7] ^ v;
    if (ar) begin
      f[FLAG_C] = t[8];
      f[FLAG_H] = h;
    end
    return {t[7:0], f};
  endfunction : alu

  function automatic logic [23:0] wop(input logic s,
    input logic [15:0] p, input logic [7:0] k, f);
    logic [16:0] t;
    logic v;
    t = s ? p - k : p + k;
    v = s ? p[15] & ~t[15] : ~p[15] & t[15];
    f[FLAG_C] = t[16];
    f[FLAG_Z] = t[15:0] == 16'h0000;
    f[FLAG_N] = t[15];
    f[FLAG_V] = v;
    f[FLAG_S] = t[15] ^ v;
    return {t[15:0], f};
  endfunction : wop

  // ==========================================================
  // Drivers and comparisons
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_b(input logic got, input logic exp);
    chk_v({15'h0000, got}, {15'h0000, exp});
  endtask : chk_b
  task automatic drive(input cpa_op_e o, input logic [7:0] x, y, z, ad,
    input logic [2:0] b);
    op_i <= o;
    rd_data_i <= x;
    rr_data_i <= y;
    imm_i <= z;
    io_addr_i <= ad;
    bit_i <= b;
    pair_i <= {x, y};
    z_ptr_i <= {z, x};
    op_valid_i <= 1'b1;
  endtask : drive
  task automatic send(input cpa_op_e o, input logic [7:0] x, y, z, ad,
    input logic [2:0] b);
    @(posedge clk_i);
    drive(o, x, y, z, ad, b);
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask : send
  task automatic xio(input cpa_op_e o, input logic [7:0] ad,
    input logic [2:0] b, input logic we, re, input logic [7:0] ea);
    send(o, 8'h3c, 8'h00, 8'h00, ad, b);
    chk_b(io_we_o, we);
    chk_b(io_re_o, re);
    if (we || re) begin
      chk_v(io_addr_o, ea);
    end
    if (we && o inside {CPA_IO_BIT_SET, CPA_IO_BIT_CLEAR}) begin
      chk_v(io_mask_o, 8'h01 << b);
      chk_v(io_wdata_o, o == CPA_IO_BIT_SET ? 8'hff : 8'h00);
      chk_b(ready_o, 1'b0);
    end
  endtask : xio
  task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge clk_i);
    bus_addr_i <= ad;
    bus_re_i <= 1'b1;
    @(posedge clk_i);
    bus_re_i <= 1'b0;
    @(negedge clk_i);
    chk_v(bus_rdata_o, exp);
  endtask : rd
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    bus_addr_i <= ad;
    bus_wdata_i <= d;
    bus_we_i <= 1'b1;
    @(posedge clk_i);
    bus_we_i <= 1'b0;
  endtask : wr
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk_b(ready_o, 1'b1);
    chk_v(flags_o, 8'h00);
    // Back-to-back single-cycle operations, corner operands first
    @(posedge clk_i);
    for (int i = 0; i <= 200; i++) begin
      px = ex;
      if (i < 200) begin
        a = (i < 4) ? cor[i] : 8'($random(seed));
        r = (i < 4) ? 8'h01 : 8'($random(seed));
        k = (i < 4) ? 8'h01 : 8'($random(seed));
        o = ops[$unsigned($random(seed)) % 17];
        ex = alu(o, a, r, k, ef);
        ef = ex[7:0];
        drive(o, a, r, k, 8'h00, 3'h0);
      end else begin
        op_valid_i <= 1'b0;
      end
      @(negedge clk_i);
      if (i > 0) begin
        chk_b(rd_we_o, 1'b1);
        chk_v(result_o, px[15:8]);
        chk_v(flags_o, px[7:0]);
      end
      @(posedge clk_i);
    end
    rd(REG_RESULT, px[15:8]);
    wr(REG_FLAGS, 8'hc3);
    rd(REG_FLAGS, 8'hc3);
    ef = 8'hc3;
    send(CPA_INDIRECT_JUMP, 8'h34, 8'h00, 8'h12, 8'h00, 3'h0);
    chk_v(pc_o, 16'h1234);
    chk_b(pc_load_o, 1'b0);
    @(negedge clk_i);
    chk_b(pc_load_o, 1'b1);
    chk_v(flags_o, ef);
    rd(REG_PC_HI, 8'h12);
    for (int i = 0; i < 4; i++) begin
      r = {8{wh[i][7] ^ i[1]}};
      wx = wop(i[0], {wh[i], r}, 8'h01, ef);
      send(i[0] ? CPA_WORD_SUBTRACT_IMMEDIATE : CPA_WORD_ADD_IMMEDIATE,
        wh[i], r, 8'h01, 8'h00, 3'h0);
      chk_v(flags_o, wx[7:0]);
      chk_b(word_we_o, 1'b0);
      @(negedge clk_i);
      chk_b(word_we_o, 1'b1);
      chk_v(word_o, wx[23:8]);
      ef = wx[7:0];
    end
    xio(CPA_IO_BIT_SET, 8'h05, 3'h7, 1'b1, 1'b0, 8'h25);
    xio(CPA_IO_BIT_CLEAR, 8'h1f, 3'h0, 1'b1, 1'b0, 8'h3f);
    for (int i = 0; i < 6; i++) begin
      xio(i < 3 ? CPA_PORT_READ : CPA_DATA_SPACE_LOAD, ra[i], 3'h0,
        1'b0, 1'b1, ea[i]);
      @(negedge clk_i);
      chk_v(result_o, rv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      xio(i[0] ? CPA_IO_BIT_SKIP_IF_ZERO : CPA_IO_BIT_SKIP_IF_ONE,
        i[1] ? 8'h1f : 8'h05, i[1] ? 3'h0 : 3'h7, 1'b0, 1'b1,
        i[1] ? 8'h3f : 8'h25);
      @(negedge clk_i);
      chk_b(skip_o, i[0] == i[1]);
    end
    xio(CPA_PORT_WRITE, 8'h3f, 3'h0, 1'b1, 1'b0, 8'h5f);
    xio(CPA_DATA_SPACE_STORE, 8'h80, 3'h0, 1'b1, 1'b0, 8'h80);
    xio(CPA_IO_BIT_SET, 8'h20, 3'h1, 1'b0, 1'b0, 8'h00);
    xio(CPA_PORT_READ, 8'h40, 3'h0, 1'b0, 1'b0, 8'h00);
    xio(CPA_DATA_SPACE_LOAD, 8'h1f, 3'h0, 1'b0, 1'b0, 8'h00);
    rd(REG_ERROR, 8'h07);
    wr(REG_ERROR, 8'h07);
    rd(REG_ERROR, 8'h00);
    rd(4'hf, 8'h00);
    test_done();
  end
endmodule : cpu_alu_and_io_access_tb
